// ===== test/array_model.sv
// Purpose : Behavioural model of the nonvolatile array behind the write controller
// Assumes : Array controls are registered levels and pulses in the pclk domain
// Notes   : Reports each committed byte once, in load order, one per cycle
`timescale 1ns/100ps
module array_model (
  // Clock
  input  wire logic        pclk,
  output logic             timer_clk,
  // Array controls
  input  wire logic [6:0]  arr_addr,
  input  wire logic [7:0]  arr_wdata,
  input  wire logic        arr_load,
  input  wire logic        arr_erase,
  input  wire logic        arr_program,
  input  wire logic        arr_page,
  // Observed activity
  output logic             commit_valid,
  output logic [14:0]      commit_word,
  output logic [7:0]       erase_cnt,
  output logic [6:0]       erase_addr
);
  logic [14:0] load_q[$];
  logic [14:0] pend_q[$];
  logic        erase_q = 1'b0;
  logic        prog_q  = 1'b0;
  logic [7:0]  ecnt_q  = 8'h00;
  logic [6:0]  eaddr_q = 7'h00;

  // ****************************************
  // Write timer
  // ****************************************
  // Free running at 17 pclk periods, rising edges landing on pclk rising edges, so tick capture is exercised
  initial begin
    timer_clk = 1'b0;
    forever #170 timer_clk = ~timer_clk;
  end

  // ****************************************
  // Array activity
  // ****************************************
  // Erase tally lives in one process only, so each output keeps a single driver
  assign erase_cnt  = ecnt_q;
  assign erase_addr = eaddr_q;
  // Edges of erase and program mark one operation each; page data waits in a latch
  always @(posedge pclk) begin
    commit_valid <= 1'b0;
    erase_q      <= arr_erase;
    prog_q       <= arr_program;
    if (arr_erase && !erase_q) begin
      ecnt_q  <= ecnt_q + 8'h01;
      eaddr_q <= arr_addr;
    end
    if (arr_load) load_q.push_back({arr_addr, arr_wdata});
    if (arr_program && !prog_q) begin
      if (arr_page) begin
        pend_q = load_q;
        load_q.delete();
      end else begin
        pend_q.push_back({arr_addr, arr_wdata});
      end
    end
    if (pend_q.size() > 0) begin
      commit_valid <= 1'b1;
      commit_word  <= pend_q.pop_front();
    end
  end
endmodule

// ===== test/tb_eeprom_write_control.sv
// Purpose : Self-checking bench for the data EEPROM write controller
// Assumes : APB with zero wait states, default timer counts
// Notes   : Expected reads and array commits wait in queues until seen
`timescale 1ns/100ps
module tb_eeprom_write_control;
  typedef struct { logic [31:0] val; logic [31:0] mask; } note_s;
  logic        pclk, presetn, psel, penable, pwrite, stack_full, irq_ack;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, q;
  logic        pready, pslverr, timer_clk, irq_vector_req, e;
  logic [6:0]  arr_addr, erase_addr, a;
  logic [7:0]  arr_wdata, erase_cnt, d;
  logic [2:0]  pg;
  logic        arr_load, arr_erase, arr_program, arr_page, commit_valid;
  logic [14:0] commit_word;
  note_s       exp_rd[$];
  note_s       n;
  logic [14:0] exp_arr[$];
  int          num_errors, total_checks, cycles;

  // ****************************************
  // Design, array model, clock
  // ****************************************
  eeprom_write_control uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .timer_clk(timer_clk), .stack_full(stack_full), .irq_ack(irq_ack),
    .irq_vector_req(irq_vector_req), .arr_addr(arr_addr), .arr_wdata(arr_wdata),
    .arr_load(arr_load), .arr_erase(arr_erase), .arr_program(arr_program), .arr_page(arr_page));
  array_model far (.pclk(pclk), .timer_clk(timer_clk), .arr_addr(arr_addr),
    .arr_wdata(arr_wdata), .arr_load(arr_load), .arr_erase(arr_erase),
    .arr_program(arr_program), .arr_page(arr_page), .commit_valid(commit_valid),
    .commit_word(commit_word), .erase_cnt(erase_cnt), .erase_addr(erase_addr));
  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end

  // ****************************************
  // Checking and closing
  // ****************************************
  task automatic check_word(input string nm, input logic [31:0] ex, input logic [31:0] sn);
    total_checks++;
    if (sn !== ex) begin
      num_errors++;
      $display("BAD %s expected %h seen %h", nm, ex, sn);
    end
  endtask
  task automatic complete_run();
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // Oldest note is matched against each completed read and each array commit
  always @(posedge pclk) begin
    if (psel && penable && pready && !pwrite && exp_rd.size() > 0) begin
      n = exp_rd.pop_front();
      if (n.mask !== 32'h0) check_word("prdata", n.val & n.mask, prdata & n.mask);
    end
    if (commit_valid) begin
      if (exp_arr.size() == 0) check_word("commit", 32'hffffffff, {17'h0, commit_word});
      else check_word("commit", {17'h0, exp_arr.pop_front()}, {17'h0, commit_word});
    end
  end
  // A hang counts as a mismatch and ends the run
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 30000) begin
      num_errors++;
      complete_run();
    end
  end

  // ****************************************
  // APB master
  // ****************************************
  task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] wd,
                     output logic [31:0] rd_q, output logic err);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= ad;
    pwdata  <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd_q = prdata;
    err  = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] ad, input logic [31:0] wd);
    logic [31:0] r;
    logic        x;
    apb(1'b1, ad, wd, r, x);
    check_word("pslverr", 32'h0, {31'h0, x});
  endtask
  task automatic rd(input logic [7:0] ad, input logic [31:0] v, input logic [31:0] m,
                    output logic [31:0] r);
    logic x;
    exp_rd.push_back('{v, m});
    apb(1'b0, ad, 32'h0, r, x);
  endtask
  // Polls the start bit, which drops when the timed cycle is over
  task automatic wait_done();
    logic [31:0] r;
    int          k;
    k = 0;
    do begin
      rd(eeprom_wr_pkg::CTL_OFF, 32'h0, 32'h0, r);
      k++;
    end while (r[eeprom_wr_pkg::WR_BIT] !== 1'b0 && k < 1000);
    if (k >= 1000) check_word("done", 32'h0, 32'h1);
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  initial begin
    void'($urandom(58));
    {presetn, psel, penable, pwrite, stack_full, irq_ack} = 6'h20;
    paddr  = 8'h00;
    pwdata = 32'h0;
    // A real falling edge, so the asynchronous reset cannot be missed at time zero
    #1 presetn = 1'b0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    // Protection after reset
    rd(eeprom_wr_pkg::PTR_OFF, 32'h0, 32'hffff, q);
    wr(eeprom_wr_pkg::CTL_OFF, 32'h08);
    wr(eeprom_wr_pkg::PTR_OFF, 32'h0100);
    rd(eeprom_wr_pkg::CTL_OFF, 32'h0, 32'h1c, q);
    wr(eeprom_wr_pkg::CTL_OFF, 32'h04);
    rd(eeprom_wr_pkg::CTL_OFF, 32'h0, 32'h1c, q);
    apb(1'b0, 8'h20, 32'h0, q, e);
    check_word("pslverr", 32'h1, {31'h0, e});
    // Any transfer between enable and start cancels the start
    wr(eeprom_wr_pkg::CTL_OFF, 32'h08);
    wr(eeprom_wr_pkg::ADDR_OFF, 32'h05);
    wr(eeprom_wr_pkg::CTL_OFF, 32'h0c);
    rd(eeprom_wr_pkg::CTL_OFF, 32'h08, 32'h1c, q);
    wr(eeprom_wr_pkg::CTL_OFF, 32'h00);
    // Byte write with automatic erase
    a = 7'($urandom);
    d = 8'($urandom);
    wr(eeprom_wr_pkg::ADDR_OFF, {25'h0, a});
    wr(eeprom_wr_pkg::DATA_OFF, {24'h0, d});
    exp_arr.push_back({a, d});
    wr(eeprom_wr_pkg::IRQ_OFF, 32'h0);
    wr(eeprom_wr_pkg::CTL_OFF, 32'h08);
    wr(eeprom_wr_pkg::CTL_OFF, 32'h0c);
    rd(eeprom_wr_pkg::CTL_OFF, 32'h0c, 32'h1c, q);
    wait_done();
    rd(eeprom_wr_pkg::CTL_OFF, 32'h0, 32'h1c, q);
    check_word("erase_cnt", 32'h1, {24'h0, erase_cnt});
    check_word("erase_addr", {25'h0, a}, {25'h0, erase_addr});
    rd(eeprom_wr_pkg::IRQ_OFF, 32'h03, 32'h1f, q);
    // Vector request needs every enable and room on the stack
    for (int i = 0; i < 4; i++) begin
      wr(eeprom_wr_pkg::IRQ_OFF, 32'h1c & ~(32'h4 << i));
      @(posedge pclk);
      check_word("irq_vector_req", {31'h0, i == 3}, {31'h0, irq_vector_req});
    end
    stack_full <= 1'b1;
    @(posedge pclk);
    check_word("irq_vector_req", 32'h0, {31'h0, irq_vector_req});
    stack_full <= 1'b0;
    irq_ack    <= 1'b1;
    @(posedge pclk);
    irq_ack <= 1'b0;
    rd(eeprom_wr_pkg::IRQ_OFF, 32'h0d, 32'h1f, q);
    wr(eeprom_wr_pkg::IRQ_OFF, 32'h03);
    rd(eeprom_wr_pkg::IRQ_OFF, 32'h0, 32'h1f, q);
    // Page write: stale entry dropped by enable fall, nibble stops at the boundary
    pg = 3'($urandom);
    wr(eeprom_wr_pkg::CTL_OFF, 32'h10);
    wr(eeprom_wr_pkg::ADDR_OFF, {25'h0, pg, 4'h0});
    wr(eeprom_wr_pkg::DATA_OFF, 32'h5a);
    wr(eeprom_wr_pkg::CTL_OFF, 32'h18);
    wr(eeprom_wr_pkg::CTL_OFF, 32'h10);
    wr(eeprom_wr_pkg::ADDR_OFF, {25'h0, pg, 4'hd});
    for (int k = 0; k < 4; k++) begin
      d = 8'($urandom);
      wr(eeprom_wr_pkg::DATA_OFF, {24'h0, d});
      if (k < 3) exp_arr.push_back({pg, 4'(4'hd + k), d});
    end
    rd(eeprom_wr_pkg::ADDR_OFF, {25'h0, pg, 4'hf}, 32'h7f, q);
    wr(eeprom_wr_pkg::CTL_OFF, 32'h18);
    wr(eeprom_wr_pkg::CTL_OFF, 32'h1c);
    wait_done();
    rd(eeprom_wr_pkg::CTL_OFF, 32'h10, 32'h1c, q);
    repeat (4) @(posedge pclk);
    check_word("erase_cnt", 32'h1, {24'h0, erase_cnt});
    check_word("pending", 32'h0, exp_arr.size());
    complete_run();
  end
endmodule

// ===== verilog/eeprom_wr_pkg.sv
// Purpose : Shared constants for the data EEPROM write controller
// Assumes : APB byte addresses, 32-bit data, one register per aligned word
// Notes   : Timer counts are defaults only; the top module takes them as parameters
package eeprom_wr_pkg;

  // ****************************************
  // Register byte offsets
  // ****************************************
  localparam logic [7:0] CTL_OFF  = 8'h00;  // eeprom_control_reg
  localparam logic [7:0] ADDR_OFF = 8'h04;  // eeprom_address_reg
  localparam logic [7:0] DATA_OFF = 8'h08;  // eeprom_data_reg
  localparam logic [7:0] IRQ_OFF  = 8'h0c;  // Flags and enables
  localparam logic [7:0] PTR_OFF  = 8'h10;  // Pointer high bytes

  // ****************************************
  // Field positions
  // ****************************************
  localparam int MODE_BIT = 4;  // Page mode select
  localparam int WEN_BIT  = 3;  // write_enable_bit
  localparam int WR_BIT   = 2;  // Write start
  localparam int EIF_BIT  = 0;  // eeprom_irq_flag, write one to clear
  localparam int MFF_BIT  = 1;  // Shared multi-function flag, write one to clear
  localparam int EIE_BIT  = 2;  // eeprom_irq_enable
  localparam int MFE_BIT  = 3;  // Multi-function enable
  localparam int GIE_BIT  = 4;  // global_irq_enable

  // ****************************************
  // Widths, reset values, counts
  // ****************************************
  localparam int AW        = 7;   // Array address width
  localparam int LOW_W     = 4;   // Word-in-page bits
  localparam int DW        = 8;   // Byte width
  localparam int PAGE_SIZE = 16;  // Page buffer entries
  localparam logic [3:0] LOW_LAST   = 4'hf;
  localparam logic [7:0] PTR_RST    = 8'h00;
  localparam logic [7:0] SECTOR_ONE = 8'h01;
  localparam logic [7:0] BYTE_RST   = 8'h00;
  localparam int ERASE_TICKS_DEF = 4;  // Slow timer edges per erase
  localparam int PROG_TICKS_DEF  = 6;  // Slow timer edges per program

  // One-hot sequencer states
  typedef enum logic [3:0] {
    ST_IDLE  = 4'b0001,
    ST_LOAD  = 4'b0010,
    ST_ERASE = 4'b0100,
    ST_PROG  = 4'b1000
  } wr_state_e;

endpackage

// ===== verilog/eeprom_write_control.sv
// Purpose : Data EEPROM write controller with APB register access
// Assumes : Timer clock is slow and asynchronous to pclk
// Notes   : Byte and page write; read and erase paths are not covered
//
// Register access over APB and the placing of the registers were decided locally.
`timescale 1ns/100ps
module eeprom_write_control #(
  parameter int ERASE_TICKS = eeprom_wr_pkg::ERASE_TICKS_DEF,
  parameter int PROG_TICKS  = eeprom_wr_pkg::PROG_TICKS_DEF,
  parameter int CNT_W       = 8
) (
  // Clock and reset
  input  wire logic                          pclk,
  input  wire logic                          presetn,
  // APB slave
  input  wire logic                          psel,
  input  wire logic                          penable,
  input  wire logic                          pwrite,
  input  wire logic [7:0]                    paddr,
  input  wire logic [31:0]                   pwdata,
  output logic      [31:0]                   prdata,
  output logic                               pready,
  output logic                               pslverr,
  // Asynchronous write timer and processor side
  input  wire logic                          timer_clk,
  input  wire logic                          stack_full,
  input  wire logic                          irq_ack,
  output logic                               irq_vector_req,
  // Array side
  output logic      [eeprom_wr_pkg::AW-1:0]  arr_addr,
  output logic      [eeprom_wr_pkg::DW-1:0]  arr_wdata,
  output logic                               arr_load,
  output logic                               arr_erase,
  output logic                               arr_program,
  output logic                               arr_page
);

  // ****************************************
  // State
  // ****************************************
  eeprom_wr_pkg::wr_state_e st_q, st_d;
  logic                                  mode_q, wen_q, wen_d, wr_q, arm_q, full_q;
  logic [eeprom_wr_pkg::AW-1:0]          addr_q;
  logic [eeprom_wr_pkg::DW-1:0]          data_q, buf_rdata;
  logic [eeprom_wr_pkg::PAGE_SIZE-1:0]   valid_q;
  logic                                  eif_q, mff_q, eie_q, mfe_q, gie_q;
  logic [7:0]                            p1h_q, p2h_q;
  logic [CNT_W-1:0]                      cnt_q;
  logic [4:0]                            idx_q;
  logic [3:0]                            lidx_q;
  logic                                  lvalid_q;
  logic                                  tmr_s1_q, tmr_s2_q, tmr_s3_q;

  // ****************************************
  // Bus decode
  // ****************************************
  wire acc     = psel & penable;
  wire wr_acc  = acc & pwrite;
  wire sector1 = (p1h_q == eeprom_wr_pkg::SECTOR_ONE) |
                 (p2h_q == eeprom_wr_pkg::SECTOR_ONE);
  wire hit_ctl  = paddr == eeprom_wr_pkg::CTL_OFF;
  wire hit_addr = paddr == eeprom_wr_pkg::ADDR_OFF;
  wire hit_data = paddr == eeprom_wr_pkg::DATA_OFF;
  wire hit_irq  = paddr == eeprom_wr_pkg::IRQ_OFF;
  wire hit_ptr  = paddr == eeprom_wr_pkg::PTR_OFF;
  wire mapped   = hit_ctl | hit_addr | hit_data | hit_irq | hit_ptr;
  wire busy     = st_q != eeprom_wr_pkg::ST_IDLE;
  // Control is only reachable with sector one selected, and frozen while busy
  wire ctl_wr   = wr_acc & hit_ctl & sector1 & ~busy;
  wire adr_wr   = wr_acc & hit_addr & ~busy;
  wire dat_wr   = wr_acc & hit_data & ~busy;
  wire irq_wr   = wr_acc & hit_irq;
  wire ptr_wr   = wr_acc & hit_ptr;

  // ****************************************
  // Handshake and timer
  // ****************************************
  wire new_wen   = pwdata[eeprom_wr_pkg::WEN_BIT];
  wire start_req = ctl_wr & pwdata[eeprom_wr_pkg::WR_BIT];
  // Start needs enable already set and armed by the previous transfer
  wire start_ok  = start_req & wen_q & arm_q;
  wire wen_rise  = ctl_wr & new_wen & ~wen_q;
  // Edge of the synchronised timer clock is one tick
  wire tick      = tmr_s2_q & ~tmr_s3_q;
  wire erase_end = (st_q == eeprom_wr_pkg::ST_ERASE) & tick &
                   (cnt_q == CNT_W'(ERASE_TICKS - 1));
  wire done      = (st_q == eeprom_wr_pkg::ST_PROG) & tick &
                   (cnt_q == CNT_W'(PROG_TICKS - 1));
  wire wen_fall  = wen_q & ~wen_d;
  wire low_last  = addr_q[eeprom_wr_pkg::LOW_W-1:0] == eeprom_wr_pkg::LOW_LAST;
  wire pg_acc    = dat_wr & mode_q & ~full_q;
  wire [eeprom_wr_pkg::AW-1:0] addr_inc = {addr_q[eeprom_wr_pkg::AW-1:eeprom_wr_pkg::LOW_W],
                                           addr_q[eeprom_wr_pkg::LOW_W-1:0] + 4'h1};

  // Enable: set by software, kept on start, cleared by hardware at the end
  assign wen_d = done     ? 1'b0 :
                 start_ok ? 1'b1 :
                 ctl_wr   ? new_wen : wen_q;

  // Two flops before anything looks at the timer clock
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tmr_s1_q <= 1'b0;
      tmr_s2_q <= 1'b0;
      tmr_s3_q <= 1'b0;
    end else begin
      tmr_s1_q <= timer_clk;
      tmr_s2_q <= tmr_s1_q;
      tmr_s3_q <= tmr_s2_q;
    end
  end

  // ****************************************
  // Control register
  // ****************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_q <= 1'b0;
      wen_q  <= 1'b0;
      wr_q   <= 1'b0;
      arm_q  <= 1'b0;
    end else begin
      mode_q <= ctl_wr ? pwdata[eeprom_wr_pkg::MODE_BIT] : mode_q;
      wen_q  <= wen_d;
      // Set by a valid start, self-clears when the timer finishes
      wr_q   <= start_ok | (wr_q & ~done);
      // Any other completed transfer breaks the back-to-back pair
      arm_q  <= acc ? wen_rise : arm_q;
    end
  end

  // ****************************************
  // Address, data and page buffer tracking
  // ****************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      addr_q  <= '0;
      data_q  <= eeprom_wr_pkg::BYTE_RST;
      full_q  <= 1'b0;
      valid_q <= '0;
    end else begin
      if (adr_wr) begin
        addr_q <= pwdata[eeprom_wr_pkg::AW-1:0];
      end else if (pg_acc && !low_last) begin
        addr_q <= addr_inc;
      end
      data_q <= dat_wr ? pwdata[eeprom_wr_pkg::DW-1:0] : data_q;
      // The last slot is taken once, then the page is closed
      full_q <= adr_wr ? 1'b0 : (wen_fall ? 1'b0 : (full_q | (pg_acc & low_last)));
      if (wen_fall) begin
        valid_q <= '0;
      end else if (pg_acc) begin
        valid_q[addr_q[eeprom_wr_pkg::LOW_W-1:0]] <= 1'b1;
      end
    end
  end

  page_buf_mem #(
    .WIDTH (eeprom_wr_pkg::DW),
    .DEPTH (eeprom_wr_pkg::PAGE_SIZE),
    .AW    (eeprom_wr_pkg::LOW_W)
  ) u_buf (
    .pclk    (pclk),
    .we      (pg_acc),
    .waddr   (addr_q[eeprom_wr_pkg::LOW_W-1:0]),
    .wdata   (pwdata[eeprom_wr_pkg::DW-1:0]),
    .raddr   (idx_q[3:0]),
    .rdata_q (buf_rdata)
  );

  // ****************************************
  // Write sequencer
  // ****************************************
  // Byte mode erases first; page mode streams the buffer then programs
  always_comb begin
    st_d = st_q;
    unique case (st_q)
      eeprom_wr_pkg::ST_IDLE: begin
        if (start_ok) begin
          st_d = mode_q ? eeprom_wr_pkg::ST_LOAD : eeprom_wr_pkg::ST_ERASE;
        end
      end
      eeprom_wr_pkg::ST_LOAD: begin
        if (idx_q == 5'(eeprom_wr_pkg::PAGE_SIZE)) begin
          st_d = eeprom_wr_pkg::ST_PROG;
        end
      end
      eeprom_wr_pkg::ST_ERASE: begin
        if (erase_end) begin
          st_d = eeprom_wr_pkg::ST_PROG;
        end
      end
      eeprom_wr_pkg::ST_PROG: begin
        if (done) begin
          st_d = eeprom_wr_pkg::ST_IDLE;
        end
      end
      default: st_d = eeprom_wr_pkg::ST_IDLE;
    endcase
  end

  // Tick counter restarts whenever the state changes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q     <= eeprom_wr_pkg::ST_IDLE;
      cnt_q    <= '0;
      idx_q    <= '0;
      lidx_q   <= '0;
      lvalid_q <= 1'b0;
    end else begin
      st_q     <= st_d;
      cnt_q    <= (st_d != st_q) ? '0 : (tick ? cnt_q + CNT_W'(1) : cnt_q);
      idx_q    <= (st_q == eeprom_wr_pkg::ST_LOAD) ? idx_q + 5'h01 : 5'h00;
      lidx_q   <= idx_q[3:0];
      lvalid_q <= (st_q == eeprom_wr_pkg::ST_LOAD) & ~idx_q[4] & valid_q[idx_q[3:0]];
    end
  end

  // ****************************************
  // Interrupt flags and pointer bytes
  // ****************************************
  // Hardware set wins over a software or service clear in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      eif_q <= 1'b0;
      mff_q <= 1'b0;
      eie_q <= 1'b0;
      mfe_q <= 1'b0;
      gie_q <= 1'b0;
      p1h_q <= eeprom_wr_pkg::PTR_RST;
      p2h_q <= eeprom_wr_pkg::PTR_RST;
    end else begin
      eif_q <= done | (eif_q & ~(irq_wr & pwdata[eeprom_wr_pkg::EIF_BIT]));
      mff_q <= done | (mff_q & ~irq_ack &
               ~(irq_wr & pwdata[eeprom_wr_pkg::MFF_BIT]));
      eie_q <= irq_wr ? pwdata[eeprom_wr_pkg::EIE_BIT] : eie_q;
      mfe_q <= irq_wr ? pwdata[eeprom_wr_pkg::MFE_BIT] : mfe_q;
      gie_q <= irq_ack ? 1'b0 : (irq_wr ? pwdata[eeprom_wr_pkg::GIE_BIT] : gie_q);
      p1h_q <= ptr_wr ? pwdata[7:0] : p1h_q;
      p2h_q <= ptr_wr ? pwdata[15:8] : p2h_q;
    end
  end

  // Vector only with every enable set and room on the stack
  assign irq_vector_req = mff_q & eie_q & mfe_q & gie_q & ~stack_full;

  // ****************************************
  // Read data and outputs
  // ****************************************
  wire [31:0] ctl_rd = {27'h0, mode_q, wen_q, wr_q, 2'b00};
  wire [31:0] irq_rd = {27'h0, gie_q, mfe_q, eie_q, mff_q, eif_q};
  assign prdata  = (hit_ctl && sector1) ? ctl_rd :
                   hit_addr ? {25'h0, addr_q} :
                   hit_data ? {24'h0, data_q} :
                   hit_irq  ? irq_rd :
                   hit_ptr  ? {16'h0, p2h_q, p1h_q} : 32'h0;
  assign pready  = 1'b1;  // Zero wait states
  assign pslverr = acc & ~mapped;

  assign arr_addr    = mode_q ? {addr_q[eeprom_wr_pkg::AW-1:eeprom_wr_pkg::LOW_W], lidx_q}
                              : addr_q;
  assign arr_wdata   = mode_q ? buf_rdata : data_q;
  assign arr_load    = lvalid_q;
  assign arr_erase   = st_q == eeprom_wr_pkg::ST_ERASE;
  assign arr_program = st_q == eeprom_wr_pkg::ST_PROG;
  assign arr_page    = mode_q;

  // ****************************************
  // Assertions
  // ****************************************
  a_start_armed: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(wr_q) |-> $past(wen_q) && $past(arm_q))
    else $error("write started without a fresh enable");
  a_start_ignored: assert property (@(posedge pclk) disable iff (!presetn)
    (start_req && !wen_q) |=> !wr_q && st_q == eeprom_wr_pkg::ST_IDLE)
    else $error("start accepted with enable clear");
  a_done_clears: assert property (@(posedge pclk) disable iff (!presetn)
    done |=> !wr_q && st_q == eeprom_wr_pkg::ST_IDLE)
    else $error("start bit not cleared at end");
  a_byte_erase: assert property (@(posedge pclk) disable iff (!presetn)
    (start_ok && !mode_q) |=> arr_erase && !arr_program)
    else $error("byte write did not erase first");
  a_page_load: assert property (@(posedge pclk) disable iff (!presetn)
    (start_ok && mode_q) |=> st_q == eeprom_wr_pkg::ST_LOAD ##17 arr_program)
    else $error("page write sequence wrong");
  a_buf_clear: assert property (@(posedge pclk) disable iff (!presetn)
    $fell(wen_q) |-> valid_q == '0 && !full_q)
    else $error("buffer kept data after enable fell");
  a_addr_step: assert property (@(posedge pclk) disable iff (!presetn)
    (pg_acc && !low_last && !adr_wr) |=> addr_q == $past(addr_inc))
    else $error("page address did not step");
  a_addr_sat: assert property (@(posedge pclk) disable iff (!presetn)
    (full_q && dat_wr) |=> $stable(addr_q) && $stable(valid_q))
    else $error("write accepted past page end");
  a_wen_clear: assert property (@(posedge pclk) disable iff (!presetn)
    done |=> !wen_q)
    else $error("enable not cleared at end");
  a_flag_set: assert property (@(posedge pclk) disable iff (!presetn)
    done |=> eif_q && mff_q)
    else $error("request flags not set at end");
  a_service: assert property (@(posedge pclk) disable iff (!presetn)
    (irq_ack && !done && !irq_wr) |=> !mff_q && !gie_q && eif_q == $past(eif_q))
    else $error("service cleared wrong flags");

endmodule

// ===== verilog/page_buf_mem.sv
// Purpose : Small page buffer memory with registered read data
// Assumes : Single clock, one write and one read port
// Notes   : Contents are not cleared; the controller tracks valid entries
`timescale 1ns/100ps
module page_buf_mem #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16,
  parameter int AW    = 4
) (
  // Clock
  input  wire logic             pclk,
  // Write port
  input  wire logic             we,
  input  wire logic [AW-1:0]    waddr,
  input  wire logic [WIDTH-1:0] wdata,
  // Read port
  input  wire logic [AW-1:0]    raddr,
  output logic      [WIDTH-1:0] rdata_q
);

  logic [WIDTH-1:0] mem [DEPTH];

  // Storage has no reset, so it maps onto plain RAM cells
  always_ff @(posedge pclk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    rdata_q <= mem[raddr];
  end

endmodule
